// ===== region_lockdown_fault_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Span enable bit 31 gates whether the count code locks anything.
// RULE2: Code k locks regions top down to top minus k.
// RULE3: Selector can make the span control register read-only.
// RULE4: Selector writes accepted only while boot lockout stays low.
// RULE5: Lockout high one cycle blocks all later selector writes.
// RULE6: Selector bit 2 makes early access control read-only.
// RULE7: Selector bit 1 makes trust swap enable read-only.
// RULE8: Selector bit 0 makes span control read-only.
// RULE9: Multi fault flag sets on a second failure before clear.
// RULE10: Flags bit 0 shows interrupt active.
// RULE11: Any write to acknowledge clears active and multi flags, but a failure in that same cycle keeps active set.
// RULE12: Fault address lower returns address of first failure.
// RULE13: Response select drives irq for codes 2,3; odd codes give DECERR.
// RULE14: Region count code reads regions minus one.
// RULE15: Boot lockout is sticky until reset.
// RULE16: Capture loads only while inactive or in an acknowledge cycle, and holds until clear.
module region_lockdown_fault_regs #(
  parameter int REGIONS = rlfr_pkg::RLFR_REGIONS_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic boot_lock_in,
  input wire logic fail_in,
  input wire logic [rlfr_pkg::RLFR_ADDR_W-1:0] fail_addr_in,
  output logic fault_irq_out,
  output logic decerr_out,
  output logic [REGIONS-1:0] locked_out,
  output logic early_ctrl_out,
  output logic tswap_en_out
);
  import rlfr_pkg::*;

  // The region count field describes 1 to 16 regions; only 2 to 16 are accepted.
  if (REGIONS < 2 || REGIONS > 16) begin : g_bad_regions
    $error("REGIONS must be 2 to 16");
  end

  // ==========================================================================
  // Reset release and lockout synchroniser.
  logic rst_meta;
  logic rst_n;
  logic lock_meta;
  logic lock_sync;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      lock_meta <= boot_lock_in;
      lock_sync <= lock_meta;
    end
  end

  // ==========================================================================
  // Register state.
  logic boot_locked;
  logic span_en;
  logic [3:0] span_code;
  logic [2:0] wp_sel;
  logic [1:0] action;
  logic irq_active;
  logic multi_fault;
  logic [RLFR_ADDR_W-1:0] fault_addr;
  logic early_ctrl;
  logic tswap_en;

  logic wr_span;
  logic wr_sel;
  logic wr_ack;
  logic wr_action;
  logic wr_early;
  logic wr_tswap;

  assign wr_span = wr_in && addr_in == RLFR_OFF_SPAN && !wp_sel[RLFR_SEL_SPAN_BIT]; // RULE3 RULE8
  assign wr_sel = wr_in && addr_in == RLFR_OFF_WPSEL && !boot_locked && !lock_sync; // RULE4 RULE5
  assign wr_ack = wr_in && addr_in == RLFR_OFF_ACK;
  assign wr_action = wr_in && addr_in == RLFR_OFF_ACTION;
  assign wr_early = wr_in && addr_in == RLFR_OFF_EARLY && !wp_sel[RLFR_SEL_EARLY_BIT]; // RULE6
  assign wr_tswap = wr_in && addr_in == RLFR_OFF_TSWAP && !wp_sel[RLFR_SEL_TSWAP_BIT]; // RULE7

  // Sticky lockout flag.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      boot_locked <= 1'b0;
    end else if (lock_sync) begin
      boot_locked <= 1'b1; // RULE15
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      span_en <= 1'b0;
      span_code <= 4'h0;
    end else if (wr_span) begin
      span_en <= wdata_in[RLFR_SPAN_EN_BIT];
      span_code <= wdata_in[3:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wp_sel <= 3'h0;
    end else if (wr_sel) begin
      wp_sel <= wdata_in[2:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      action <= RLFR_RST_ACTION;
    end else if (wr_action) begin
      action <= wdata_in[1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      early_ctrl <= 1'b0;
    end else if (wr_early) begin
      early_ctrl <= wdata_in[0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tswap_en <= 1'b0;
    end else if (wr_tswap) begin
      tswap_en <= wdata_in[0];
    end
  end

  // ==========================================================================
  // Fault capture. A failure in the acknowledge cycle keeps the active flag set and loads its address; the multi flag still clears.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_active <= 1'b0;
    end else if (fail_in) begin
      irq_active <= 1'b1; // RULE10
    end else if (wr_ack) begin
      irq_active <= 1'b0; // RULE11
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      multi_fault <= 1'b0;
    end else if (fail_in && irq_active && !wr_ack) begin
      multi_fault <= 1'b1; // RULE9
    end else if (wr_ack) begin
      multi_fault <= 1'b0; // RULE11
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fault_addr <= RLFR_RST_ZERO;
    end else if (fail_in && (!irq_active || wr_ack)) begin
      fault_addr <= fail_addr_in; // RULE12 RULE16
    end
  end

  // ==========================================================================
  // Lock decode.
  rlfr_lock_if #(.REGIONS(REGIONS)) lk ();
  assign lk.enable = span_en;
  assign lk.code = span_code;

  rlfr_lock_decode #(.REGIONS(REGIONS)) u_dec (
    .lk(lk)
  );

  // Both outputs are registered so that decode ripple never reaches the pins.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      locked_out <= {REGIONS{1'b0}};
    end else begin
      locked_out <= lk.locked; // RULE1 RULE2
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fault_irq_out <= 1'b0;
    end else begin
      fault_irq_out <= irq_active && action[1]; // RULE13
    end
  end

  assign decerr_out = action[0]; // RULE13
  assign early_ctrl_out = early_ctrl;
  assign tswap_en_out = tswap_en;

  // ==========================================================================
  // Read data, one cycle after the strobe.
  logic [31:0] next_rdata;
  localparam logic [3:0] REGION_CODE = 4'(REGIONS - 1);

  always_comb begin
    next_rdata = RLFR_RST_ZERO;
    unique case (addr_in)
      RLFR_OFF_CONFIG: next_rdata = {28'h0, REGION_CODE}; // RULE14
      RLFR_OFF_ACTION: next_rdata = {30'h0, action};
      RLFR_OFF_SPAN: next_rdata = {span_en, 27'h0, span_code};
      RLFR_OFF_WPSEL: next_rdata = {29'h0, wp_sel};
      RLFR_OFF_FLAGS: next_rdata = {30'h0, multi_fault, irq_active}; // RULE9 RULE10
      RLFR_OFF_FADDR: next_rdata = fault_addr; // RULE12
      RLFR_OFF_EARLY: next_rdata = {31'h0, early_ctrl};
      RLFR_OFF_TSWAP: next_rdata = {31'h0, tswap_en};
      default: next_rdata = RLFR_RST_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= RLFR_RST_ZERO;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= RLFR_RST_ZERO;
    end
  end

  // ==========================================================================
  // Checks.
  sequence s_span_write;
    wr_in && addr_in == RLFR_OFF_SPAN;
  endsequence

  property p_span_ro;
    @(posedge ref_clk_in) disable iff (!rst_n)
    (s_span_write and wp_sel[0]) |=> $stable({span_en, span_code});
  endproperty
  a_span_ro: assert property (p_span_ro) else $error("span changed while protected"); // RULE8

  property p_sel_locked;
    @(posedge ref_clk_in) disable iff (!rst_n)
    boot_locked |=> $stable(wp_sel);
  endproperty
  a_sel_locked: assert property (p_sel_locked) else $error("selector changed after lock"); // RULE5

  property p_lock_sticky;
    @(posedge ref_clk_in) disable iff (!rst_n)
    boot_locked |=> boot_locked;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lockout flag dropped"); // RULE15

  property p_early_ro;
    @(posedge ref_clk_in) disable iff (!rst_n)
    wp_sel[2] |=> $stable(early_ctrl);
  endproperty
  a_early_ro: assert property (p_early_ro) else $error("early control changed"); // RULE6

  property p_tswap_ro;
    @(posedge ref_clk_in) disable iff (!rst_n)
    wp_sel[1] |=> $stable(tswap_en);
  endproperty
  a_tswap_ro: assert property (p_tswap_ro) else $error("trust swap changed"); // RULE7

  property p_multi;
    @(posedge ref_clk_in) disable iff (!rst_n)
    (fail_in && irq_active && !wr_ack) |=> multi_fault;
  endproperty
  a_multi: assert property (p_multi) else $error("multi fault not set"); // RULE9

  property p_ack;
    @(posedge ref_clk_in) disable iff (!rst_n)
    (wr_ack && !fail_in) |=> !irq_active && !multi_fault;
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not clear"); // RULE11

  property p_hold_addr;
    @(posedge ref_clk_in) disable iff (!rst_n)
    (irq_active && !wr_ack) |=> $stable(fault_addr);
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("fault address overwritten"); // RULE16

  property p_irq_out;
    @(posedge ref_clk_in) disable iff (!rst_n)
    fault_irq_out == $past(irq_active && action[1]);
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq output wrong"); // RULE13

  property p_top_lock;
    @(posedge ref_clk_in) disable iff (!rst_n)
    $past(span_en) |->
      locked_out[REGIONS-1] && (!locked_out[0] == (int'($past(span_code)) < REGIONS - 1));
  endproperty
  a_top_lock: assert property (p_top_lock) else $error("lock decode wrong"); // RULE1 RULE2

  sequence s_sel_write;
    wr_in && addr_in == RLFR_OFF_WPSEL;
  endsequence

  sequence s_fresh_fail;
    fail_in && (!irq_active || wr_ack);
  endsequence

  property p_sel_write;
    @(posedge ref_clk_in) disable iff (!rst_n)
    (s_sel_write and (!boot_locked && !lock_sync)) |=> wp_sel == $past(wdata_in[2:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selector write lost"); // RULE4

  property p_lock_seen;
    @(posedge ref_clk_in) disable iff (!rst_n)
    lock_sync |=> boot_locked;
  endproperty
  a_lock_seen: assert property (p_lock_seen) else $error("lockout not latched"); // RULE5 RULE15

  property p_fail_sets;
    @(posedge ref_clk_in) disable iff (!rst_n)
    fail_in |=> irq_active;
  endproperty
  a_fail_sets: assert property (p_fail_sets) else $error("failure did not raise status"); // RULE10

  property p_capture;
    @(posedge ref_clk_in) disable iff (!rst_n)
    s_fresh_fail |=> fault_addr == $past(fail_addr_in);
  endproperty
  a_capture: assert property (p_capture) else $error("first address not captured"); // RULE12 RULE16

  property p_flags_read;
    @(posedge ref_clk_in) disable iff (!rst_n)
    (rd_in && addr_in == RLFR_OFF_FLAGS) |=>
      rdata_out == {30'h0, $past(multi_fault), $past(irq_active)};
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flags read wrong"); // RULE9 RULE10

  property p_cfg_read;
    @(posedge ref_clk_in) disable iff (!rst_n)
    (rd_in && addr_in == RLFR_OFF_CONFIG) |=> rdata_out == {28'h0, REGION_CODE};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("region count read wrong"); // RULE14

  property p_decerr;
    @(posedge ref_clk_in) disable iff (!rst_n)
    decerr_out == action[0];
  endproperty
  a_decerr: assert property (p_decerr) else $error("error response wrong"); // RULE13

  property p_span_off;
    @(posedge ref_clk_in) disable iff (!rst_n)
    !$past(span_en) |-> locked_out == {REGIONS{1'b0}};
  endproperty
  a_span_off: assert property (p_span_off) else $error("lock without enable"); // RULE1
endmodule : region_lockdown_fault_regs

// ===== rlfr_pkg.sv
package rlfr_pkg;
  // ==========================================================================
  // Register offsets (byte addresses).
  localparam logic [11:0] RLFR_OFF_CONFIG = 12'h000;
  localparam logic [11:0] RLFR_OFF_ACTION = 12'h004;
  localparam logic [11:0] RLFR_OFF_SPAN = 12'h008;
  localparam logic [11:0] RLFR_OFF_WPSEL = 12'h00c;
  localparam logic [11:0] RLFR_OFF_FLAGS = 12'h010;
  localparam logic [11:0] RLFR_OFF_ACK = 12'h014;
  localparam logic [11:0] RLFR_OFF_FADDR = 12'h020;
  localparam logic [11:0] RLFR_OFF_EARLY = 12'h034;
  localparam logic [11:0] RLFR_OFF_TSWAP = 12'h038;
  // ==========================================================================
  // Field positions.
  localparam int RLFR_SPAN_EN_BIT = 31;
  localparam int RLFR_SEL_EARLY_BIT = 2;
  localparam int RLFR_SEL_TSWAP_BIT = 1;
  localparam int RLFR_SEL_SPAN_BIT = 0;
  localparam int RLFR_FLG_MULTI_BIT = 1;
  localparam int RLFR_FLG_ACT_BIT = 0;
  localparam int RLFR_ADDR_W = 32;
  localparam int RLFR_REGIONS_DEF = 16;
  // ==========================================================================
  // Reset values.
  localparam logic [31:0] RLFR_RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RLFR_RST_ACTION = 2'h0;
endpackage : rlfr_pkg

// ===== rlfr_lock_if.sv
`timescale 1ns/1ps
interface rlfr_lock_if #(parameter int REGIONS = 16);
  logic enable;
  logic [3:0] code;
  logic [REGIONS-1:0] locked;
  modport ctrl (output enable, output code, input locked);
  modport dec (input enable, input code, output locked);
endinterface : rlfr_lock_if

// ===== rlfr_lock_decode.sv
`timescale 1ns/1ps
module rlfr_lock_decode #(
  parameter int REGIONS = 16
) (
  rlfr_lock_if.dec lk
);
  import rlfr_pkg::*;
  // ==========================================================================
  // Region i is locked when it lies within the top code+1 regions.
  always_comb begin
    for (int i = 0; i < REGIONS; i++) begin
      lk.locked[i] = lk.enable && (i >= (REGIONS - 1 - int'(lk.code))); // RULE1 RULE2
    end
  end
endmodule : rlfr_lock_decode

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rlfr_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic boot_lock_in = 1'b0;
  logic fail_in = 1'b0;
  logic [31:0] fail_addr_in = 32'h0000_0000;
  logic [31:0] rdata_out;
  logic fault_irq_out;
  logic decerr_out;
  logic [15:0] locked_out;
  logic early_ctrl_out;
  logic tswap_en_out;
  int num_errors = 0;
  int checked = 0;

  region_lockdown_fault_regs #(.REGIONS(16)) dut (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .boot_lock_in(boot_lock_in),
    .fail_in(fail_in),
    .fail_addr_in(fail_addr_in),
    .fault_irq_out(fault_irq_out),
    .decerr_out(decerr_out),
    .locked_out(locked_out),
    .early_ctrl_out(early_ctrl_out),
    .tswap_en_out(tswap_en_out)
  );

  initial begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // ==========================================================================
  // Bus and check helpers.
  task complete_run;
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : reg_wr

  task rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp, what);
  endtask : rd_chk

  task settle;
    @(posedge ref_clk_in);
    #1;
  endtask : settle

  task fail_pulse(input logic [31:0] a);
    @(posedge ref_clk_in);
    fail_in <= 1'b1;
    fail_addr_in <= a;
    @(posedge ref_clk_in);
    fail_in <= 1'b0;
  endtask : fail_pulse

  // ==========================================================================
  // Scenarios.
  task test_span;
    logic [31:0] wv [4] = '{32'h8000_0003, 32'h0000_0003, 32'h8000_0000, 32'h8000_000f};
    logic [15:0] lv [4] = '{16'hf000, 16'h0000, 16'h8000, 16'hffff};
    rd_chk(RLFR_OFF_CONFIG, 32'h0000_000f, "region count");
    rd_chk(12'h0fc, 32'h0000_0000, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      reg_wr(RLFR_OFF_SPAN, wv[i]);
      settle();
      chk({16'h0000, locked_out}, {16'h0000, lv[i]}, "locked regions");
    end
    rd_chk(RLFR_OFF_SPAN, 32'h8000_000f, "span readback");
  endtask : test_span

  task test_fault;
    rd_chk(RLFR_OFF_FLAGS, 32'h0000_0000, "flags after reset");
    fail_pulse(32'hdead_0010);
    rd_chk(RLFR_OFF_FLAGS, 32'h0000_0001, "single fault flags");
    for (int a = 0; a < 4; a++) begin
      reg_wr(RLFR_OFF_ACTION, a);
      settle();
      chk({31'h0, fault_irq_out}, {31'h0, a[1]}, "irq level");
      chk({31'h0, decerr_out}, {31'h0, a[0]}, "error response");
    end
    rd_chk(RLFR_OFF_ACTION, 32'h0000_0003, "action readback");
    fail_pulse(32'hbeef_0020);
    rd_chk(RLFR_OFF_FLAGS, 32'h0000_0003, "multi fault flags");
    rd_chk(RLFR_OFF_FADDR, 32'hdead_0010, "first fault address");
    reg_wr(RLFR_OFF_ACK, 32'h1234_5678);
    rd_chk(RLFR_OFF_FLAGS, 32'h0000_0000, "flags after ack");
    chk({31'h0, fault_irq_out}, 32'h0, "irq after ack");
    fail_pulse(32'h0000_0c30);
    rd_chk(RLFR_OFF_FADDR, 32'h0000_0c30, "address after ack");
    reg_wr(RLFR_OFF_ACK, 32'h0000_0000);
  endtask : test_fault

  task test_protect;
    reg_wr(RLFR_OFF_EARLY, 32'h0000_0001);
    reg_wr(RLFR_OFF_TSWAP, 32'h0000_0001);
    reg_wr(RLFR_OFF_SPAN, 32'h8000_0001);
    reg_wr(RLFR_OFF_WPSEL, 32'h0000_0007);
    reg_wr(RLFR_OFF_EARLY, 32'h0000_0000);
    reg_wr(RLFR_OFF_TSWAP, 32'h0000_0000);
    reg_wr(RLFR_OFF_SPAN, 32'h0000_0000);
    settle();
    chk({31'h0, early_ctrl_out}, 32'h1, "early locked");
    chk({31'h0, tswap_en_out}, 32'h1, "swap locked");
    chk({16'h0000, locked_out}, 32'h0000_c000, "span locked");
    rd_chk(RLFR_OFF_SPAN, 32'h8000_0001, "span held");
    rd_chk(RLFR_OFF_TSWAP, 32'h0000_0001, "swap held");
    reg_wr(RLFR_OFF_WPSEL, 32'h0000_0000);
    rd_chk(RLFR_OFF_WPSEL, 32'h0000_0000, "selector open");
    reg_wr(RLFR_OFF_EARLY, 32'h0000_0000);
    settle();
    chk({31'h0, early_ctrl_out}, 32'h0, "early writable");
    rd_chk(RLFR_OFF_EARLY, 32'h0000_0000, "early readback");
  endtask : test_protect

  task test_lockout;
    @(posedge ref_clk_in);
    boot_lock_in <= 1'b1;
    @(posedge ref_clk_in);
    boot_lock_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    reg_wr(RLFR_OFF_WPSEL, 32'h0000_0004);
    rd_chk(RLFR_OFF_WPSEL, 32'h0000_0000, "selector frozen");
    reg_wr(RLFR_OFF_EARLY, 32'h0000_0001);
    settle();
    chk({31'h0, early_ctrl_out}, 32'h1, "early still writable");
  endtask : test_lockout

  // A failure in the acknowledge cycle must keep the active flag set over the clear, while the multi flag still clears.
  task test_collide;
    fail_pulse(32'h0000_1100);
    fail_pulse(32'h0000_2200);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= RLFR_OFF_ACK;
    wdata_in <= 32'h0000_0000;
    fail_in <= 1'b1;
    fail_addr_in <= 32'h0000_5a40;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    fail_in <= 1'b0;
    rd_chk(RLFR_OFF_FLAGS, 32'h0000_0001, "fail beats ack");
    rd_chk(RLFR_OFF_FADDR, 32'h0000_5a40, "address after collision");
    chk({31'h0, fault_irq_out}, 32'h1, "irq after collision");
    rd_chk(RLFR_OFF_ACK, 32'h0000_0000, "ack reads zero");
    reg_wr(RLFR_OFF_ACK, 32'h0000_0000);
    rd_chk(RLFR_OFF_FLAGS, 32'h0000_0000, "flags cleared");
  endtask : test_collide

  // Only reset may clear the sticky lockout.
  task test_rearm;
    fail_pulse(32'h0000_7700);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #1;
    chk({16'h0000, locked_out}, 32'h0000_0000, "locked after reset");
    rd_chk(RLFR_OFF_FLAGS, 32'h0000_0000, "flags after reset");
    rd_chk(RLFR_OFF_FADDR, 32'h0000_0000, "address after reset");
    reg_wr(RLFR_OFF_WPSEL, 32'h0000_0004);
    rd_chk(RLFR_OFF_WPSEL, 32'h0000_0004, "selector rearmed");
  endtask : test_rearm

  // ==========================================================================
  // Main sequence and watchdog.
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    test_span();
    test_fault();
    test_collide();
    test_protect();
    test_lockout();
    test_rearm();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    num_errors++;
    complete_run();
  end
endmodule : tb_top
